//--- ppc_protect.sv
// Operation
// - Charge block on OV, OT or overcurrent
// - Keep charge FET on during discharge over 50mA
// - Charge FET back on; overcurrent needs below 256mA
// - Discharge block on overdischarge or overload
// - Keep discharge FET on during charge 50mA+
// - Discharge FET back on; overload needs above -256mA
// - Front-end trips clear at zero current
// - Short-circuit delay byte, nibbles per direction
// - Trip output low only when safety enabled
// - Trip output and flag latch until reset
// - Trip on charge block plus overvoltage 1s
// - Trip on charge block plus overtemp 1s
// - Trip when check failures reach limit
// - Periodic front-end check, slower in sleep
// - Count failed front-end checks, saturating at 0xFFFF
// - Charge block flag four set conditions
// - Optional double measurement confirmation
// - Cell undervoltage: open discharge, shutdown 10.975V
// - FETs switched only by front-end commands
// - Partial reset rewrites all front-end registers
// - Overtemp set at max, clear at hysteresis/43C
`timescale 1ns/1ps
`include "ppc_regs.svh"
module ppc_protect #(
   parameter int CW = 16,
   parameter int CELLS = 4,
   parameter int SEC_CYCLES = `PPC_SEC_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic partial_rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic meas_valid,
   input wire logic [CW-1:0] pack_voltage,
   input wire logic [CW*CELLS-1:0] cell_voltage,
   input wire logic signed [CW-1:0] mean_current_value,
   input wire logic signed [CW-1:0] temperature,
   input wire logic frontend_alert_input,
   output logic [2:0] afe_cmd,
   output logic [15:0] afe_data,
   output logic afe_valid,
   input wire logic afe_ready,
   input wire logic afe_check_done,
   input wire logic afe_check_ok,
   output logic safe_trip_n
);
   import ppc_pkg::*;
   initial
   begin
      if (CW < 16 || CELLS < 1 || SEC_CYCLES < 1)
         $error("ppc_protect: unsupported parameters");
   end

   typedef struct packed {
      logic [31:0] rdata;
      logic ack;
      logic [7:0] ctrl;
      logic [15:0] ov_margin, chg_v, fast_i, oc_margin, cell_ov, cell_uv, ovl_i;
      logic [15:0] tmax, thyst, safe_v, safe_t, chk_time, fail_lim, slp_mul;
      logic [7:0] sc_dly;
      logic chg_block, dsg_block, chg_by_oc, dsg_by_ovl, ot, alert_trip;
      logic chg_fet, dsg_fet, trip, uv_done;
      logic pend_c, pend_d;
      logic [15:0] fail_cnt;
      logic [31:0] sec_div;
      logic [15:0] chk_sec, safe_sec;
      logic [4:0] pend;
      ppc_afe_st_t st;
      logic [2:0] cmd;
      logic [15:0] data;
      logic a_m1, a_m2;
   } ppc_state_t;

   ppc_state_t s, n;
   logic sec_tick, safe_en, chk_en, dbl, sleep_mode;
   logic any_cell_ov, any_cell_uv, ov_now, oc_now, ovl_now, od_now, ot_set, ot_clr;
   logic chg_fault, dsg_fault, dsg_flow, chg_flow, want_chg, want_dsg;
   logic signed [CW:0] cur;
   logic [31:0] chk_period;

   function automatic logic [15:0] wmask(input logic [15:0] old, input logic [31:0] wd,
      input logic [3:0] be);
      wmask = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction : wmask

   function automatic logic sgt(input logic signed [CW:0] a, input logic signed [CW:0] b);
      sgt = a > b;
   endfunction : sgt

   assign safe_en = s.ctrl[`PPC_CTRL_SAFE_EN];
   assign chk_en = s.ctrl[`PPC_CTRL_CHECK_EN];
   assign dbl = s.ctrl[`PPC_CTRL_DOUBLE];
   assign sleep_mode = s.ctrl[`PPC_CTRL_SLEEP];
   assign sec_tick = (s.sec_div == 32'(SEC_CYCLES - 1));
   assign cur = {mean_current_value[CW-1], mean_current_value};
   assign chk_period = sleep_mode ? 32'(s.chk_time) * 32'(s.slp_mul)
      : {16'h0000, s.chk_time};

   always_comb
   begin
      any_cell_ov = 1'b0;
      any_cell_uv = 1'b0;
      for (int i = 0; i < CELLS; i++)
      begin
         if (cell_voltage[i*CW +: 16] >= s.cell_ov) any_cell_ov = 1'b1;
         if (cell_voltage[i*CW +: 16] <= s.cell_uv) any_cell_uv = 1'b1;
      end
   end

   assign ov_now = ({1'b0, pack_voltage[15:0]} >= {1'b0, s.chg_v} + {1'b0, s.ov_margin})
      || any_cell_ov;
   assign oc_now = !sgt((CW+1)'({1'b0, s.fast_i}) + (CW+1)'({1'b0, s.oc_margin}), cur);
   assign ovl_now = !sgt(cur, -(CW+1)'({1'b0, s.ovl_i}));
   assign od_now = any_cell_uv;
   assign ot_set = !sgt((CW+1)'({1'b0, s.tmax}), {temperature[CW-1], temperature});
   assign ot_clr = !sgt({temperature[CW-1], temperature},
      (CW+1)'({1'b0, s.tmax}) - (CW+1)'({1'b0, s.thyst}))
      || !sgt({temperature[CW-1], temperature}, (CW+1)'({1'b0, `PPC_OT_FLOOR}));
   assign dsg_flow = sgt(-(CW+1)'({1'b0, `PPC_FLOW_MA}), cur);
   assign chg_flow = !sgt((CW+1)'({1'b0, `PPC_FLOW_MA}), cur);

   always_comb
   begin
      n = s;
      n.ack = 1'b0;
      n.a_m1 = frontend_alert_input;
      n.a_m2 = s.a_m1;
      n.sec_div = sec_tick ? 32'h0 : s.sec_div + 32'h1;
      chg_fault = 1'b0;
      dsg_fault = 1'b0;
      if (s.a_m2) n.alert_trip = 1'b1;
      // Writes land at the edge where waitrequest is seen low
      if (avs_read || avs_write)
      begin
         n.ack = !s.ack;
         if (!s.ack) n.rdata = 32'h0;
         if (avs_write && s.ack)
         begin
            case (avs_address)
               `PPC_REG_CTRL: if (avs_byteenable[0]) n.ctrl = avs_writedata[7:0];
               `PPC_REG_OVMARGIN: n.ov_margin = wmask(s.ov_margin, avs_writedata, avs_byteenable);
               `PPC_REG_CHGV: n.chg_v = wmask(s.chg_v, avs_writedata, avs_byteenable);
               `PPC_REG_FASTI: n.fast_i = wmask(s.fast_i, avs_writedata, avs_byteenable);
               `PPC_REG_OCMARGIN: n.oc_margin = wmask(s.oc_margin, avs_writedata, avs_byteenable);
               `PPC_REG_CELLOV: n.cell_ov = wmask(s.cell_ov, avs_writedata, avs_byteenable);
               `PPC_REG_CELLUV: n.cell_uv = wmask(s.cell_uv, avs_writedata, avs_byteenable);
               `PPC_REG_OVLI: n.ovl_i = wmask(s.ovl_i, avs_writedata, avs_byteenable);
               `PPC_REG_TMAX: n.tmax = wmask(s.tmax, avs_writedata, avs_byteenable);
               `PPC_REG_THYST: n.thyst = wmask(s.thyst, avs_writedata, avs_byteenable);
               `PPC_REG_SAFEV: n.safe_v = wmask(s.safe_v, avs_writedata, avs_byteenable);
               `PPC_REG_SAFET: n.safe_t = wmask(s.safe_t, avs_writedata, avs_byteenable);
               `PPC_REG_CHKTIME: n.chk_time = wmask(s.chk_time, avs_writedata, avs_byteenable);
               `PPC_REG_FAILLIM: n.fail_lim = wmask(s.fail_lim, avs_writedata, avs_byteenable);
               `PPC_REG_SCDLY: if (avs_byteenable[0])
               begin
                  n.sc_dly = avs_writedata[7:0];
                  n.pend[PPC_CMD_SCDLY] = 1'b1;
               end
               `PPC_REG_SLPMUL: n.slp_mul = wmask(s.slp_mul, avs_writedata, avs_byteenable);
               default: n.rdata = 32'h0;
            endcase
         end
         else if (!s.ack)
         begin
            case (avs_address)
               `PPC_REG_CTRL: n.rdata = {24'h0, s.ctrl};
               `PPC_REG_OVMARGIN: n.rdata = {16'h0, s.ov_margin};
               `PPC_REG_CHGV: n.rdata = {16'h0, s.chg_v};
               `PPC_REG_FASTI: n.rdata = {16'h0, s.fast_i};
               `PPC_REG_OCMARGIN: n.rdata = {16'h0, s.oc_margin};
               `PPC_REG_CELLOV: n.rdata = {16'h0, s.cell_ov};
               `PPC_REG_CELLUV: n.rdata = {16'h0, s.cell_uv};
               `PPC_REG_OVLI: n.rdata = {16'h0, s.ovl_i};
               `PPC_REG_TMAX: n.rdata = {16'h0, s.tmax};
               `PPC_REG_THYST: n.rdata = {16'h0, s.thyst};
               `PPC_REG_SAFEV: n.rdata = {16'h0, s.safe_v};
               `PPC_REG_SAFET: n.rdata = {16'h0, s.safe_t};
               `PPC_REG_CHKTIME: n.rdata = {16'h0, s.chk_time};
               `PPC_REG_FAILLIM: n.rdata = {16'h0, s.fail_lim};
               `PPC_REG_SCDLY: n.rdata = {24'h0, s.sc_dly};
               `PPC_REG_SLPMUL: n.rdata = {16'h0, s.slp_mul};
               `PPC_REG_STATUS: n.rdata = {26'h0, s.ot, s.dsg_fet, s.chg_fet, s.trip,
                  s.dsg_block, s.chg_block};
               `PPC_REG_FAILCNT: n.rdata = {16'h0, s.fail_cnt};
               default: n.rdata = 32'h0;
            endcase
         end
      end

      // Evaluation on each measurement; double mode needs two agreeing samples, except overtemp which blocks charge on one
      if (meas_valid)
      begin
         n.pend_c = ov_now || oc_now || ot_set;
         n.pend_d = od_now || ovl_now;
         chg_fault = dbl ? (s.pend_c && n.pend_c) : n.pend_c;
         dsg_fault = dbl ? (s.pend_d && n.pend_d) : n.pend_d;
         if (ot_set) n.ot = 1'b1;
         else if (ot_clr) n.ot = 1'b0;
         if (chg_fault || n.ot)
         begin
            n.chg_block = 1'b1;
            if (oc_now) n.chg_by_oc = 1'b1;
         end
         else if (!ov_now && !n.ot &&
            (!s.chg_by_oc || sgt((CW+1)'({1'b0, `PPC_RECOVER_MA}), cur)))
         begin
            n.chg_block = 1'b0;
            n.chg_by_oc = 1'b0;
         end
         if (dsg_fault)
         begin
            n.dsg_block = 1'b1;
            if (ovl_now) n.dsg_by_ovl = 1'b1;
         end
         else if (!od_now &&
            (!s.dsg_by_ovl || sgt(cur, -(CW+1)'({1'b0, `PPC_RECOVER_MA}))))
         begin
            n.dsg_block = 1'b0;
            n.dsg_by_ovl = 1'b0;
         end
         if (any_cell_uv && !s.uv_done)
         begin
            n.uv_done = 1'b1;
            n.pend[PPC_CMD_SHUTDOWN] = 1'b1;
         end
         else if (!any_cell_uv) n.uv_done = 1'b0;
         if (!s.a_m2 && s.alert_trip && cur == '0)
         begin
            n.alert_trip = 1'b0;
            n.pend[PPC_CMD_CHG_FET] = 1'b1;
            n.pend[PPC_CMD_DSG_FET] = 1'b1;
         end
      end
      want_chg = !(n.chg_block && !dsg_flow);
      want_dsg = !(n.dsg_block && !chg_flow);
      if (want_chg != s.chg_fet)
      begin
         n.chg_fet = want_chg;
         n.pend[PPC_CMD_CHG_FET] = 1'b1;
      end
      if (want_dsg != s.dsg_fet)
      begin
         n.dsg_fet = want_dsg;
         n.pend[PPC_CMD_DSG_FET] = 1'b1;
      end

      // Safety trip timing
      if (!s.chg_block) n.safe_sec = 16'h0;
      else if (sec_tick && s.safe_sec != 16'hFFFF) n.safe_sec = s.safe_sec + 16'h1;
      // Two ticks guarantee a full second of block, whatever the divider phase
      if (safe_en && s.chg_block && s.safe_sec >= 16'h2 &&
         (pack_voltage[15:0] > s.safe_v || sgt({temperature[CW-1], temperature},
         (CW+1)'({1'b0, s.safe_t})))) n.trip = 1'b1;
      if (safe_en && chk_en && s.fail_lim != 16'h0 && s.fail_cnt >= s.fail_lim)
         n.trip = 1'b1;

      // Periodic check
      if (sec_tick)
      begin
         if ({16'h0, s.chk_sec} + 32'h1 >= chk_period && chk_period != 32'h0)
         begin
            n.chk_sec = 16'h0;
            n.pend[PPC_CMD_CHECK] = 1'b1;
         end
         else n.chk_sec = s.chk_sec + 16'h1;
      end
      if (afe_check_done && !afe_check_ok && s.fail_cnt != 16'hFFFF)
         n.fail_cnt = s.fail_cnt + 16'h1;

      // Front-end command sequencer, lowest index first
      case (s.st)
         PPC_AFE_IDLE:
         begin
            for (int k = 4; k >= 0; k--)
            begin
               if (s.pend[k])
               begin
                  n.cmd = 3'(k);
               end
            end
            if (s.pend != 5'h0)
            begin
               n.st = PPC_AFE_REQ;
               n.pend[n.cmd] = 1'b0;
               case (ppc_cmd_t'(n.cmd))
                  PPC_CMD_CHG_FET: n.data = {15'h0, n.chg_fet};
                  PPC_CMD_DSG_FET: n.data = {15'h0, n.dsg_fet};
                  PPC_CMD_SCDLY: n.data = {8'h0, n.sc_dly};
                  PPC_CMD_SHUTDOWN: n.data = `PPC_SHUTDOWN_MV;
                  default: n.data = 16'h0;
               endcase
            end
         end
         PPC_AFE_REQ: if (afe_ready) n.st = PPC_AFE_IDLE;
         default: n.st = PPC_AFE_IDLE;
      endcase
      if (partial_rst) n.pend = n.pend | 5'h07;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         s <= '0;
         s.ctrl <= `PPC_CTRL_RST;
         s.sc_dly <= `PPC_SCDLY_RST;
         s.chg_fet <= 1'b1;
         s.dsg_fet <= 1'b1;
         s.pend <= 5'h07;
      end
      else
         s <= n;
   end

   assign avs_waitrequest = (avs_read || avs_write) && !s.ack;
   assign avs_readdata = s.rdata;
   assign afe_valid = (s.st == PPC_AFE_REQ);
   assign afe_cmd = s.cmd;
   assign afe_data = s.data;
   assign safe_trip_n = !s.trip;

   trip_latch_a: assert property (@(posedge ref_clk) disable iff (rst)
      s.trip |=> s.trip && !safe_trip_n) else $error("trip released");
   trip_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(s.trip) |-> $past(safe_en)) else $error("trip without enable");
   chg_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(s.chg_fet) |-> $past(!dsg_flow)) else $error("chg fet opened in dsg");
   dsg_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(s.dsg_fet) |-> $past(!chg_flow)) else $error("dsg fet opened in chg");
   fail_inc_a: assert property (@(posedge ref_clk) disable iff (rst)
      afe_check_done && !afe_check_ok && s.fail_cnt < 16'h00FF |=> s.fail_cnt == $past(s.fail_cnt) + 16'h1)
      else $error("fail count stuck");
   cmd_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      afe_valid && !afe_ready |=> afe_valid && $stable(afe_data)) else $error("cmd dropped");
   chg_fet_a: assert property (@(posedge ref_clk) disable iff (rst)
      $changed(s.chg_fet) |-> s.pend[PPC_CMD_CHG_FET] || afe_valid) else $error("no chg cmd");
   ot_set_a: assert property (@(posedge ref_clk) disable iff (rst)
      meas_valid && ot_set |=> s.ot && s.chg_block) else $error("ot not set");
   trip_cv: cover property (@(posedge ref_clk) $rose(s.trip));
   chg_cv: cover property (@(posedge ref_clk) $fell(s.chg_fet));
   dsg_cv: cover property (@(posedge ref_clk) $fell(s.dsg_fet));
endmodule : ppc_protect

//--- ppc_regs.svh
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH
// Register byte offsets
`define PPC_REG_CTRL 8'h00
`define PPC_REG_OVMARGIN 8'h04
`define PPC_REG_CHGV 8'h08
`define PPC_REG_FASTI 8'h0C
`define PPC_REG_OCMARGIN 8'h10
`define PPC_REG_CELLOV 8'h14
`define PPC_REG_CELLUV 8'h18
`define PPC_REG_OVLI 8'h1C
`define PPC_REG_TMAX 8'h20
`define PPC_REG_THYST 8'h24
`define PPC_REG_SAFEV 8'h28
`define PPC_REG_SAFET 8'h2C
`define PPC_REG_CHKTIME 8'h30
`define PPC_REG_FAILLIM 8'h34
`define PPC_REG_SCDLY 8'h38
`define PPC_REG_SLPMUL 8'h3C
`define PPC_REG_STATUS 8'h40
`define PPC_REG_FAILCNT 8'h44
// Control register fields
`define PPC_CTRL_SAFE_EN 0
`define PPC_CTRL_CHECK_EN 5
`define PPC_CTRL_DOUBLE 1
`define PPC_CTRL_SLEEP 2
// Status bits
`define PPC_ST_CHG_BLOCK 0
`define PPC_ST_DSG_BLOCK 1
`define PPC_ST_TRIP 2
`define PPC_ST_CHG_FET 3
`define PPC_ST_DSG_FET 4
`define PPC_ST_OT 5
// Reset values and thresholds (mA, 0.1 C, mV)
`define PPC_CTRL_RST 8'h00
`define PPC_SCDLY_RST 8'h00
`define PPC_FLOW_MA 16'h0032
`define PPC_RECOVER_MA 16'h0100
`define PPC_OT_FLOOR 16'h01AE
`define PPC_SHUTDOWN_MV 16'h2ADF
// Timing
`define PPC_SEC_NS 1000000000
`define PPC_CLK_NS 5
`define PPC_SEC_CYCLES (`PPC_SEC_NS / `PPC_CLK_NS)
`endif

//--- ppc_pkg.sv
package ppc_pkg;
   typedef enum logic [1:0] {PPC_AFE_IDLE, PPC_AFE_REQ} ppc_afe_st_t;
   typedef enum logic [2:0] {PPC_CMD_CHG_FET = 3'h0, PPC_CMD_DSG_FET = 3'h1,
      PPC_CMD_SCDLY = 3'h2, PPC_CMD_SHUTDOWN = 3'h3, PPC_CMD_CHECK = 3'h4} ppc_cmd_t;
endpackage : ppc_pkg

//--- ppc_afe_model.sv
`timescale 1ns/1ps
module ppc_afe_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [2:0] afe_cmd,
   input wire logic [15:0] afe_data,
   input wire logic afe_valid,
   output logic afe_ready,
   output logic afe_check_done,
   output logic afe_check_ok,
   output logic frontend_alert_input,
   input wire logic [3:0] delay,
   input wire logic alert_req,
   input wire logic bad_regs
);
   import ppc_pkg::*;
   logic [18:0] rxq[$];
   int cnt;
   // Alert raised while an over-current or short event lasts
   assign frontend_alert_input = alert_req;
   always @(posedge ref_clk)
   begin
      afe_check_done <= 1'b0;
      // Ok line carries no meaning outside a done pulse
      afe_check_ok <= ~afe_check_ok;
      if (rst)
      begin
         afe_ready <= 1'b0;
         afe_check_ok <= 1'b0;
         cnt <= 0;
      end
      else if (afe_valid && afe_ready)
      begin
         afe_ready <= 1'b0;
         rxq.push_back({afe_cmd, afe_data});
         if (afe_cmd == PPC_CMD_CHECK)
         begin
            afe_check_done <= 1'b1;
            afe_check_ok <= !bad_regs;
         end
      end
      else if (afe_valid && cnt >= delay)
      begin
         afe_ready <= 1'b1;
         cnt <= 0;
      end
      else if (afe_valid)
         cnt <= cnt + 1;
   end
endmodule : ppc_afe_model

//--- ppc_tb.sv
`timescale 1ns/1ps
`include "ppc_regs.svh"
module testbench;
   import ppc_pkg::*;
   typedef struct {int v; int c; int i; int t; logic [18:0] e1; logic [18:0] e2;} ppc_step_t;
   localparam int SEC = 20;
   localparam logic [18:0] NONE = 19'h7FFFF;
   localparam int cfg [13] = '{200, 12000, 2000, 500, 4300, 2800, 3000, 600, 50, 12500, 700, 1, 2};
   ppc_step_t steps [16] = '{
      '{12300, 3000, -100, 250, NONE, NONE},
      '{12300, 3000, 0, 250, 19'h00000, NONE},
      '{11000, 3000, 0, 250, 19'h00001, NONE},
      '{11000, 3000, 2600, 250, 19'h00000, NONE},
      '{11000, 3000, 1000, 250, NONE, NONE},
      '{11000, 3000, 100, 250, 19'h00001, NONE},
      '{11000, 3000, -3000, 250, 19'h10000, NONE},
      '{11000, 3000, -300, 250, NONE, NONE},
      '{11000, 3000, -100, 250, 19'h10001, NONE},
      '{11000, 2700, 0, 250, 19'h10000, 19'h32ADF},
      '{11000, 3000, 0, 250, 19'h10001, NONE},
      '{11000, 4300, 0, 250, 19'h00000, NONE},
      '{11000, 3000, 0, 250, 19'h00001, NONE},
      '{11000, 3000, 0, 600, 19'h00000, NONE},
      '{11000, 3000, 0, 560, NONE, NONE},
      '{11000, 3000, 0, 550, 19'h00001, NONE}};
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic partial_rst = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic meas_valid = 1'b0;
   logic [15:0] pack_voltage = 16'h2AF8;
   logic [63:0] cell_voltage = {4{16'h0BB8}};
   logic signed [15:0] mean_current_value = 16'h0000;
   logic signed [15:0] temperature = 16'h00FA;
   logic alert;
   logic [2:0] afe_cmd;
   logic [15:0] afe_data;
   logic afe_valid, afe_ready, chk_done, chk_ok, safe_trip_n;
   logic [3:0] delay = 4'h0;
   logic alert_req = 1'b0;
   logic bad_regs = 1'b0;
   int fails = 0;
   int n_tests = 0;
   logic [31:0] seed = 32'h83E0;
   logic [31:0] rd;
   logic [18:0] expq[$];
   always #2.5 ref_clk = ~ref_clk;
   ppc_protect #(.SEC_CYCLES(SEC)) dut (.ref_clk(ref_clk), .rst(rst), .partial_rst(partial_rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .meas_valid(meas_valid), .pack_voltage(pack_voltage),
      .cell_voltage(cell_voltage), .mean_current_value(mean_current_value),
      .temperature(temperature), .frontend_alert_input(alert), .afe_cmd(afe_cmd),
      .afe_data(afe_data), .afe_valid(afe_valid), .afe_ready(afe_ready),
      .afe_check_done(chk_done), .afe_check_ok(chk_ok), .safe_trip_n(safe_trip_n));
   ppc_afe_model afe (.ref_clk(ref_clk), .rst(rst), .afe_cmd(afe_cmd), .afe_data(afe_data),
      .afe_valid(afe_valid), .afe_ready(afe_ready), .afe_check_done(chk_done),
      .afe_check_ok(chk_ok), .frontend_alert_input(alert), .delay(delay),
      .alert_req(alert_req), .bad_regs(bad_regs));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   task cmp_val(input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         fails++;
         $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : cmp_val
   task cmp_cmd(input logic [18:0] g);
      int i;
      i = -1;
      n_tests++;
      foreach (expq[j]) if (expq[j] === g) i = j;
      if (i >= 0)
         expq.delete(i);
      else
      begin
         fails++;
         $display("ERROR t=%0t exp=%h got=%h", $time, expq.size() ? expq[0] : 19'h0, g);
      end
   endtask : cmp_cmd
   // Collects front-end commands until all expected ones came and 40 quiet cycles passed
   task drain();
      int k;
      int t;
      k = 0;
      for (t = 0; k < 40 && t < 3000; t++)
      begin
         @(posedge ref_clk);
         while (afe.rxq.size() > 0)
            if (afe.rxq[0][18:16] != PPC_CMD_CHECK) cmp_cmd(afe.rxq.pop_front());
            else void'(afe.rxq.pop_front());
         k = expq.size() ? 0 : k + 1;
      end
      if (t == 3000)
      begin
         fails++;
         tally_and_finish();
      end
   endtask : drain
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      for (k = 0; k < 50; k++)
      begin
         @(posedge ref_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (k == 50)
      begin
         fails++;
         tally_and_finish();
      end
   endtask : bus
   task meas(input int v, input int c, input int i, input int t);
      @(posedge ref_clk);
      pack_voltage <= 16'(v);
      cell_voltage <= {{3{16'h0BB8}}, 16'(c)};
      mean_current_value <= 16'(i);
      temperature <= 16'(t);
      meas_valid <= 1'b1;
      @(posedge ref_clk);
      meas_valid <= 1'b0;
   endtask : meas
   task do_reset(input logic [7:0] ctl);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      afe.rxq.delete();
      expq = '{19'h00001, 19'h10001, 19'h20000};
      rst <= 1'b0;
      drain();
      foreach (cfg[i]) bus(1'b1, 8'(4 + 4 * i), 32'(cfg[i]));
      bus(1'b1, `PPC_REG_CTRL, 32'(ctl));
   endtask : do_reset
   initial
   begin
      int k;
      do_reset(8'h01);
      bus(1'b0, `PPC_REG_CTRL, 32'h0);
      cmp_val(32'h1, rd);
      bus(1'b1, `PPC_REG_STATUS, 32'hFF);
      bus(1'b0, `PPC_REG_STATUS, 32'h0);
      cmp_val(32'h18, rd);
      bus(1'b0, 8'h80, 32'h0);
      cmp_val(32'h0, rd);
      $display("test registers done");
      foreach (steps[s])
      begin
         seed = lfsr(seed);
         delay <= {1'b0, seed[2:0]};
         meas(steps[s].v, steps[s].c, steps[s].i, steps[s].t);
         if (steps[s].e1 != NONE) expq.push_back(steps[s].e1);
         if (steps[s].e2 != NONE) expq.push_back(steps[s].e2);
         drain();
      end
      $display("test fet control done");
      @(posedge ref_clk);
      alert_req <= 1'b1;
      repeat (4) @(posedge ref_clk);
      alert_req <= 1'b0;
      repeat (3) @(posedge ref_clk);
      meas(11000, 3000, 0, 250);
      expq = '{19'h00001, 19'h10001};
      drain();
      $display("test alert clear done");
      seed = lfsr(seed);
      bus(1'b1, `PPC_REG_SCDLY, {24'h0, seed[7:0]});
      repeat (40) @(posedge ref_clk);
      afe.rxq.delete();
      partial_rst <= 1'b1;
      @(posedge ref_clk);
      partial_rst <= 1'b0;
      expq = '{19'h00001, 19'h10001, {3'h2, 8'h00, seed[7:0]}};
      drain();
      bus(1'b0, `PPC_REG_SCDLY, 32'h0);
      cmp_val({24'h0, seed[7:0]}, rd);
      $display("test partial reset done");
      for (k = 0; k < 3; k++)
      begin
         do_reset(k < 2 ? 8'h01 : 8'h00);
         for (int s = 0; s < 12; s++)
         begin
            meas(k == 1 ? 11000 : 12600, 3000, 0, k == 1 ? 750 : 250);
            if (s == 9) cmp_val(32'h1, {31'h0, safe_trip_n});
         end
         expq.push_back(19'h00000);
         drain();
         cmp_val({31'h0, k == 2}, {31'h0, safe_trip_n});
         meas(11000, 3000, 0, 250);
         expq.push_back(19'h00001);
         drain();
         bus(1'b0, `PPC_REG_STATUS, 32'h0);
         cmp_val({31'h0, k < 2}, {31'h0, rd[2]});
         cmp_val({31'h0, k == 2}, {31'h0, safe_trip_n});
         $display("test safety case %0d done", k);
      end
      do_reset(8'h02);
      meas(12600, 3000, 0, 250);
      drain();
      meas(12600, 3000, 0, 250);
      expq.push_back(19'h00000);
      drain();
      $display("test double measure done");
      do_reset(8'h21);
      bad_regs <= 1'b1;
      for (k = 0; k < 400 && safe_trip_n !== 1'b0; k++) @(posedge ref_clk);
      cmp_val(32'h0, {31'h0, safe_trip_n});
      bus(1'b0, `PPC_REG_FAILCNT, 32'h0);
      cmp_val(32'h2, rd);
      $display("test check failures done");
      tally_and_finish();
   end
endmodule : testbench
